// [logic/rx_drop_csr_bridge_flow_ctrl.sv]
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "rx_drop_csr_regs.svh"

// Overview of operation
// - 32-bit dropped frame tally, reset zero
// - reading tally returns count, clears it
// - event pulse on 7FFFFFFF to 80000000 step
// - host writes busy one to start access
// - busy held until MAC done, self-clears
// - command bit 30: one read, zero write
// - command bits 7:0 select MAC register
// - data register feeds writes, catches reads
// - no pause or jam while transmitter off
// - high mark in 64-byte fill units
// - full duplex: one pause at high mark, only with the any-frame enable set
// - half duplex: matching frames jammed for duration
// - low mark: zero-time pause below it
// - zero pause only after earlier high pause
// - jam duration table, 10M adds 2.2us
// - per-type enables: jam matching frames in half duplex, also gate the zero pause in full duplex
// - any-frame enable overrides per-type enables
module rx_drop_csr_bridge_flow_ctrl (
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   input  wire logic [7:0]                    reg_addr,
   input  wire logic [31:0]                   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [31:0]                   reg_rdata,
   input  wire logic                          frame_dropped,
   output logic                              tally_midpoint_event,
   output rx_drop_csr_pkg::mac_req_s          mac_req,
   input  wire logic                          mac_done,
   input  wire logic [31:0]                   mac_rdata,
   input  wire logic [15:0]                   pause_time_value,
   input  wire logic [13:0]                   rx_fifo_used_bytes,
   input  wire rx_drop_csr_pkg::rx_frame_s    rx_frame,
   input  wire logic                          full_duplex,
   input  wire logic                          speed_10m,
   input  wire logic                          tx_enabled,
   output logic                              pause_send,
   output logic      [15:0]                   pause_send_time,
   output logic                              jam_active
);
   logic [31:0] tally_q, tally_d;
   logic        busy_q;
   logic        rw_sel_q;
   logic [7:0]  mac_addr_q;
   logic [31:0] data_q;
   logic        req_q;
   rx_drop_csr_pkg::throttle_cfg_s cfg_q;
   rx_drop_csr_pkg::bridge_state_e st_q;
   logic        paused_q;
   logic        above_q;
   logic [15:0] jam_cnt_q;
   logic [31:0] rdata_q;
   logic        mid_q;
   logic        pause_q;
   logic [15:0] pause_time_q;

   wire sel_tally = reg_addr == `OFS_DROPPED_FRAME_COUNT;
   wire sel_cmd   = reg_addr == `OFS_MAC_BRIDGE_COMMAND;
   wire sel_data  = reg_addr == `OFS_MAC_BRIDGE_DATA;
   wire sel_cfg   = reg_addr == `OFS_AUTO_THROTTLE_CFG;

   wire tally_clr = reg_rd & sel_tally;
   // a drop in the same cycle as the clearing read is counted into the fresh tally
   wire [31:0] tally_base = tally_clr ? `RST_WORD : tally_q;
   wire [31:0] tally_inc  = tally_base + 32'h0000_0001;
   assign tally_d = frame_dropped ? tally_inc : tally_base;
   wire mid_hit = frame_dropped & ~tally_clr & (tally_q == `TALLY_MIDPOINT_LO);

   wire start = reg_wr & sel_cmd & reg_wdata[`BIT_BRIDGE_BUSY] & ~busy_q;
   // writes to command or data while busy are dropped, protecting the access in flight
   wire cmd_wr  = reg_wr & sel_cmd & ~busy_q;
   wire data_wr = reg_wr & sel_data & ~busy_q;

   wire [31:0] cmd_word = {busy_q, rw_sel_q, 22'h00_0000, mac_addr_q};
   wire [31:0] cfg_word = {8'h00, cfg_q.fill_high_mark, cfg_q.fill_low_mark, cfg_q.jam_duration,
                           cfg_q.jam_on_group_frames, cfg_q.jam_on_everyone_frames,
                           cfg_q.jam_on_own_frames, cfg_q.throttle_on_every_frame};
   wire [31:0] rd_mux = sel_tally ? tally_q :
                        sel_cmd   ? cmd_word :
                        sel_data  ? data_q :
                        sel_cfg   ? cfg_word : `RST_WORD;

   // fill level in 64-byte units
   wire [7:0] fill_units = 8'(rx_fifo_used_bytes / 14'(`FILL_UNIT_BYTES));
   wire at_high = (cfg_q.fill_high_mark != 8'h00) & (fill_units >= cfg_q.fill_high_mark);
   wire below_low = fill_units < cfg_q.fill_low_mark;

   wire any_en  = cfg_q.throttle_on_every_frame;
   wire type_en = cfg_q.jam_on_group_frames | cfg_q.jam_on_everyone_frames | cfg_q.jam_on_own_frames;
   wire fc_en   = any_en | type_en;

   // pause frames only in full duplex with transmitter running
   wire high_pause = tx_enabled & full_duplex & any_en & at_high & ~above_q;
   wire low_pause  = tx_enabled & full_duplex & fc_en & paused_q & below_low;

   wire frame_match = rx_frame.valid &
                      (any_en |
                       (cfg_q.jam_on_group_frames & rx_frame.is_group) |
                       (cfg_q.jam_on_everyone_frames & rx_frame.is_everyone) |
                       (cfg_q.jam_on_own_frames & rx_frame.is_own));
   wire jam_start = tx_enabled & ~full_duplex & at_high & frame_match;

   logic [15:0] jam_base_us;
   always_comb begin
      case (cfg_q.jam_duration)
         4'h0:    jam_base_us = 16'd5;
         4'h1:    jam_base_us = 16'd10;
         4'h2:    jam_base_us = 16'd15;
         4'h3:    jam_base_us = 16'd25;
         default: jam_base_us = 16'(({12'h000, cfg_q.jam_duration} - 16'd3) * 16'd50);
      endcase
   end
   // us to cycles at 100 MHz; wide product so a longer table entry saturates instead of wrapping
   wire [22:0] jam_cyc_full = 23'(jam_base_us) * 23'd100 +
                              (speed_10m ? 23'(`JAM_EXTRA_10M_CYC) : 23'h00_0000);
   wire [15:0] jam_load = (jam_cyc_full > 23'h00_ffff) ? 16'hffff : jam_cyc_full[15:0];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tally_q  <= `RST_WORD;
         mid_q    <= 1'b0;
         rdata_q  <= `RST_WORD;
      end else begin
         tally_q  <= tally_d;
         mid_q    <= mid_hit;
         if (reg_rd) rdata_q <= rd_mux;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q       <= rx_drop_csr_pkg::BR_IDLE;
         busy_q     <= 1'b0;
         req_q      <= 1'b0;
         rw_sel_q   <= 1'b0;
         mac_addr_q <= 8'h00;
         data_q     <= `RST_WORD;
      end else begin
         req_q <= 1'b0;
         if (cmd_wr) begin
            rw_sel_q   <= reg_wdata[`BIT_READ_WRITE_SELECT];
            mac_addr_q <= reg_wdata[7:0];
         end
         if (data_wr) data_q <= reg_wdata;
         case (st_q)
            rx_drop_csr_pkg::BR_IDLE: begin
               if (start) begin
                  busy_q <= 1'b1;
                  req_q  <= 1'b1;
                  st_q   <= rx_drop_csr_pkg::BR_WAIT;
               end
            end
            rx_drop_csr_pkg::BR_WAIT: begin
               if (mac_done) begin
                  if (rw_sel_q) data_q <= mac_rdata;
                  busy_q <= 1'b0;
                  st_q   <= rx_drop_csr_pkg::BR_IDLE;
               end
            end
            default: st_q <= rx_drop_csr_pkg::BR_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_q        <= '0;
         paused_q     <= 1'b0;
         above_q      <= 1'b0;
         jam_cnt_q    <= 16'h0000;
         pause_q      <= 1'b0;
         pause_time_q <= 16'h0000;
      end else begin
         if (reg_wr & sel_cfg) cfg_q <= reg_wdata[23:0];
         above_q <= at_high;
         pause_q <= high_pause | low_pause;
         if (high_pause) begin
            pause_time_q <= pause_time_value;
            paused_q     <= 1'b1;
         end else if (low_pause) begin
            pause_time_q <= 16'h0000;
            paused_q     <= 1'b0;
         end
         if (!tx_enabled) jam_cnt_q <= 16'h0000;
         else if (jam_start) jam_cnt_q <= jam_load;
         else if (jam_cnt_q != 16'h0000) jam_cnt_q <= jam_cnt_q - 16'h0001;
      end
   end

   assign reg_rdata            = rdata_q;
   assign tally_midpoint_event = mid_q;
   assign mac_req              = '{req: req_q, read: rw_sel_q, addr: mac_addr_q, wdata: data_q};
   assign pause_send           = pause_q;
   assign pause_send_time      = pause_time_q;
   assign jam_active           = jam_cnt_q != 16'h0000;
endmodule : rx_drop_csr_bridge_flow_ctrl

// [logic/rx_drop_csr_pkg.sv]
package rx_drop_csr_pkg;
   typedef struct packed {
      logic [7:0] fill_high_mark;
      logic [7:0] fill_low_mark;
      logic [3:0] jam_duration;
      logic       jam_on_group_frames;
      logic       jam_on_everyone_frames;
      logic       jam_on_own_frames;
      logic       throttle_on_every_frame;
   } throttle_cfg_s;

   typedef struct packed {
      logic       valid;
      logic       is_group;
      logic       is_everyone;
      logic       is_own;
   } rx_frame_s;

   typedef struct packed {
      logic       req;
      logic       read;
      logic [7:0] addr;
      logic [31:0] wdata;
   } mac_req_s;

   typedef enum logic [1:0] {
      BR_IDLE,
      BR_WAIT
   } bridge_state_e;
endpackage : rx_drop_csr_pkg

// [logic/rx_drop_csr_regs.svh]
`ifndef RX_DROP_CSR_REGS_SVH
`define RX_DROP_CSR_REGS_SVH
`define OFS_DROPPED_FRAME_COUNT 8'ha0
`define OFS_MAC_BRIDGE_COMMAND  8'ha4
`define OFS_MAC_BRIDGE_DATA     8'ha8
`define OFS_AUTO_THROTTLE_CFG   8'hac
`define BIT_BRIDGE_BUSY         31
`define BIT_READ_WRITE_SELECT   30
`define TALLY_MIDPOINT_LO       32'h7fff_ffff
`define RST_WORD                32'h0000_0000
`define JAM_EXTRA_10M_NS        2200
`define CLK_PERIOD_NS           10
`define JAM_EXTRA_10M_CYC       (`JAM_EXTRA_10M_NS / `CLK_PERIOD_NS)
`define FILL_UNIT_BYTES         64
`endif

// [tb/mac_model.sv]
`timescale 1ns/1ps
module mac_model (
   input wire logic                      clk,
   input wire rx_drop_csr_pkg::mac_req_s req,
   input wire logic [3:0]                lat,
   output logic                          done,
   output logic [31:0]                   rdata
);
   logic [31:0] mem [256];
   initial begin
      done = 1'b0;
      rdata = 32'h0000_0000;
   end
   // read data only valid beside done; otherwise it toggles so stale data never matches
   always @(posedge clk) begin
      if (req.req) begin
         repeat (lat) @(posedge clk);
         if (!req.read)
            mem[req.addr] <= req.wdata;
         rdata <= req.read ? mem[req.addr] : ~rdata;
         done <= 1'b1;
         @(posedge clk);
         done <= 1'b0;
         rdata <= ~rdata;
      end
   end
endmodule : mac_model

// [tb/rx_drop_csr_bridge_flow_ctrl_bench.sv]
`timescale 1ns/1ps
module rx_drop_csr_bridge_flow_ctrl_bench;
   logic                       clk, sys_rst, wr, rd, drop, done, fd, s10, txe, ps, jam, mev;
   logic [7:0]                 addr, a;
   logic [31:0]                wd, rdt, mrd, v, d;
   logic [15:0]                ptv, pst, pt;
   logic [13:0]                fill;
   logic [3:0]                 lat, j;
   rx_drop_csr_pkg::rx_frame_s frm;
   rx_drop_csr_pkg::mac_req_s  req;
   int                         fails, checks, np, nj, n, k;
   logic [7:0]                 k_list [5] = '{8'ha0, 8'ha4, 8'ha8, 8'hac, 8'h10};
   rx_drop_csr_bridge_flow_ctrl dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wd),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdt), .frame_dropped(drop), .tally_midpoint_event(mev),
      .mac_req(req), .mac_done(done), .mac_rdata(mrd), .pause_time_value(ptv), .rx_fifo_used_bytes(fill),
      .rx_frame(frm), .full_duplex(fd), .speed_10m(s10), .tx_enabled(txe), .pause_send(ps),
      .pause_send_time(pst), .jam_active(jam));
   mac_model mac (.clk(clk), .req(req), .lat(lat), .done(done), .rdata(mrd));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (ps) begin
         np <= np + 1;
         pt <= pst;
      end
      if (jam)
         nj <= nj + 1;
   end
   function automatic int jc(input logic [3:0] x, input logic t);
      jc = (x < 4 ? (x == 3 ? 25 : 5 * (x + 1)) : (x - 3) * 50) * 100 + (t ? 220 : 0);
   endfunction : jc
   task automatic print_verdict;
      if (fails == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic wrr(input logic [7:0] ad, input logic [31:0] dt);
      @(posedge clk);
      addr <= ad;
      wd <= dt;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wrr
   task automatic rdr(input logic [7:0] ad, output logic [31:0] q);
      @(posedge clk);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 q = rdt;
   endtask : rdr
   task automatic idle;
      for (int i = 0; i < 40; i++) begin
         rdr(8'ha4, v);
         if (v[31] === 1'b0)
            return;
      end
      chk(32'h1, 32'h0);
      print_verdict();
   endtask : idle
   task automatic step(input logic [13:0] f, input int e);
      @(posedge clk);
      fill <= f;
      repeat (4) @(posedge clk);
      #1 chk(np, e);
   endtask : step
   task automatic jf(input rx_drop_csr_pkg::rx_frame_s f, input int e);
      @(posedge clk);
      nj <= 0;
      frm <= f;
      @(posedge clk);
      frm <= '0;
      repeat (e + 20) @(posedge clk);
      #1 chk(nj, e);
   endtask : jf
   initial begin
      {sys_rst, wr, rd, drop, addr, wd, ptv, fill, frm, s10, lat} = '0;
      {sys_rst, fd, txe} = 3'b111;
      {fails, checks, np, nj} = '0;
      void'($urandom(32'h6272));
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (k_list[i]) begin
         rdr(k_list[i], v);
         chk(v, 32'h0000_0000);
      end
      n = $urandom_range(20, 1);
      drop <= 1'b1;
      repeat (n) @(posedge clk);
      drop <= 1'b0;
      rdr(8'ha0, v);
      chk(v, n);
      rdr(8'ha0, v);
      chk(v, 32'h0000_0000);
      repeat (4) begin
         a = $urandom;
         d = $urandom;
         lat <= $urandom_range(7, 0);
         wrr(8'ha8, d);
         wrr(8'ha4, {24'h80_0000, a});
         idle();
         wrr(8'ha8, ~d);
         wrr(8'ha4, {24'hc0_0000, a});
         idle();
         chk(v, {24'h40_0000, a});
         rdr(8'ha8, v);
         chk(v, d);
      end
      ptv <= $urandom_range(16'hffff, 1);
      wrr(8'hac, 32'h0002_0101);
      rdr(8'hac, v);
      chk(v, 32'h0002_0101);
      step(14'd200, 1);
      chk(pt, ptv);
      step(14'd130, 1);
      step(14'd10, 2);
      chk(pt, 32'h0000_0000);
      @(posedge clk);
      txe <= 1'b0;
      step(14'd200, 2);
      @(posedge clk);
      txe <= 1'b1;
      step(14'd10, 2);
      @(posedge clk);
      fd <= 1'b0;
      fill <= 14'd200;
      for (k = 0; k < 2; k++) begin
         j = $urandom_range(3, 0);
         s10 <= k[0];
         wrr(8'hac, {16'h0002, 8'h01, j, 4'b0010});
         jf(4'b1100, 0);
         jf(4'b1001, jc(j, k[0]));
      end
      wrr(8'hac, {16'h0002, 8'h01, j, 4'b0001});
      jf(4'b1000, jc(j, 1'b1));
      print_verdict();
   end
endmodule : rx_drop_csr_bridge_flow_ctrl_bench

// [tb/rx_drop_csr_chk.sv]
`timescale 1ns/1ps
module rx_drop_csr_chk (
   input wire logic                       clk,
   input wire logic                       sys_rst,
   input wire logic [7:0]                 reg_addr,
   input wire logic                       reg_rd,
   input wire logic [31:0]                reg_rdata,
   input wire logic                       frame_dropped,
   input wire logic                       tally_midpoint_event,
   input wire rx_drop_csr_pkg::mac_req_s  mac_req,
   input wire logic [15:0]                pause_time_value,
   input wire rx_drop_csr_pkg::rx_frame_s rx_frame,
   input wire logic                       full_duplex,
   input wire logic                       tx_enabled,
   input wire logic                       pause_send,
   input wire logic [15:0]                pause_send_time,
   input wire logic                       jam_active
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_rd0;
      reg_rd && reg_addr == 8'ha0 && !frame_dropped;
   endsequence
   property p_clr;
      s_rd0 ##1 !frame_dropped ##1 s_rd0 |=> reg_rdata == 32'h0000_0000;
   endproperty
   property p_hold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   property p_req;
      mac_req.req |=> !mac_req.req;
   endproperty
   property p_mid;
      tally_midpoint_event |=> !tally_midpoint_event;
   endproperty
   property p_tx;
      !tx_enabled ##1 !tx_enabled |-> !pause_send;
   endproperty
   property p_time;
      pause_send && pause_send_time != 16'h0000 |-> pause_send_time == $past(pause_time_value);
   endproperty
   property p_pulse;
      pause_send |=> !pause_send;
   endproperty
   property p_fdjam;
      rx_frame.valid && full_duplex && !jam_active |=> !jam_active;
   endproperty
   property p_jam;
      $rose(jam_active) |-> jam_active [*8];
   endproperty
   a_clr:   assert property (p_clr) else $error("tally not cleared by read");
   a_hold:  assert property (p_hold) else $error("read data moved");
   a_req:   assert property (p_req) else $error("request longer than one cycle");
   a_mid:   assert property (p_mid) else $error("midpoint event too long");
   a_tx:    assert property (p_tx) else $error("pause with transmitter off");
   a_time:  assert property (p_time) else $error("wrong pause time");
   a_pulse: assert property (p_pulse) else $error("pause repeated");
   a_fdjam: assert property (p_fdjam) else $error("jam in full duplex");
   a_jam:   assert property (p_jam) else $error("jam too short");
endmodule : rx_drop_csr_chk
bind rx_drop_csr_bridge_flow_ctrl rx_drop_csr_chk chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_dropped(frame_dropped), .mac_req(mac_req),
   .tally_midpoint_event(tally_midpoint_event), .pause_time_value(pause_time_value), .rx_frame(rx_frame),
   .full_duplex(full_duplex), .tx_enabled(tx_enabled), .pause_send(pause_send),
   .pause_send_time(pause_send_time), .jam_active(jam_active));
